// *** core/iprio_ctrl.v ***
// Interrupt priority resolver with flag, enable, priority and CPU level state.
// Assumes an APB master on pclk and a core that pulses take and return.
// Function
// [RL1] With nesting disabled, no user interrupt preempts a routine already running.
// [RL2] Software wanting no priority distinction gives every enabled source one nonzero level.
// [RL3] Software clears a source's pending flag before enabling it.
// [RL4] A source can request only while its enable bit is one.
// [RL5] A flag still set at return makes the same interrupt be taken again at once.
// [RL6] Return restores the saved program counter, low status byte and CPU level.
// [RL7] A trap keeps being requested until software clears its trap flag.
// [RL8] Raising the CPU level to 7 through the low status byte blocks all user interrupts.
// [RL9] Software saves the status word before raising the level and restores it afterwards.
// [RL10] Raising the CPU level masks user levels up to 7 only, never traps at 8 to 15.
// [RL11] The timed hold-off blocks levels 1 through 6 for its count of cycles.
// [RL12] Level 7 sources are still serviced during the timed hold-off.
// [RL13] A priority field of zero stops a source whatever its enable bit.
// [RL14] Status bits 11 to 8 report the new CPU level of the interrupt being taken.
// [RL15] Status bits 6 to 0 report the pending vector field, bit 7 reads zero.
// [RL16] Reset sets every user source priority field to level 4.
//
// Chosen here: register access over APB and the register addresses.
`default_nettype none
`include "iprio_defs.vh"

module iprio_ctrl (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [`IPRIO_NSRC-1:0] src_event,
  input wire [`IPRIO_NTRAP-1:0] trap_event,
  input wire core_take,
  input wire [15:0] core_pc,
  input wire core_return,
  output wire core_irq_req,
  output wire [3:0] core_irq_level,
  output wire [6:0] core_irq_vector,
  output wire ret_valid,
  output wire [15:0] ret_pc,
  output wire irq
);

  reg [31:0] prdata_reg;
  reg pready_reg;
  reg pslverr_reg;
  reg nest_dis_reg;
  reg [`IPRIO_NTRAP-1:0] trap_reg;
  reg [`IPRIO_NSRC-1:0] flag_reg;
  reg [`IPRIO_NSRC-1:0] en_reg;
  reg [`IPRIO_NSRC-1:0] mask_reg;
  reg [`IPRIO_PRIO_ALL_W-1:0] prio_reg;
  reg [3:0] cpu_lvl_reg;
  reg [`IPRIO_SRL_LO_W-1:0] srl_lo_reg;
  reg [3:0] lvl_out_reg;
  reg [6:0] vec_out_reg;
  reg req_reg;
  reg irq_reg;

  wire stk_empty;
  wire stk_full;
  wire stk_valid;
  wire [`IPRIO_STK_W-1:0] stk_data;
  wire hold_active;
  wire [`IPRIO_HOLD_W-1:0] hold_left;

  wire setup = psel && !penable;
  wire wr_en = psel && penable && pwrite && pready_reg;
  wire take = core_take && req_reg && !stk_full;
  wire [7:0] srl_view = cpu_lvl_reg[3] ? {`IPRIO_SRL_IPL7, srl_lo_reg} :
                        {cpu_lvl_reg[2:0], srl_lo_reg};

  function [`IPRIO_PRIO_W-1:0] prio_of;
    input [`IPRIO_PRIO_ALL_W-1:0] word;
    input integer idx;
    begin
      prio_of = word[idx*`IPRIO_PRIO_W +: `IPRIO_PRIO_W];
    end
  endfunction

  // Hardware sets win over a write-one-to-clear in the same cycle.
  function [31:0] w1c_next;
    input [31:0] cur;
    input [31:0] set;
    input [31:0] clr;
    input wr;
    begin
      w1c_next = (cur & ~(wr ? clr : 32'h00000000)) | set;
    end
  endfunction

  function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // Write strobes only fire at the access edge, so a refused or read access
  // can never disturb register state.
  wire wr_ctrl1 = wr_en && hit(paddr, `IPRIO_OFF_CTRL1);
  wire wr_flags = wr_en && hit(paddr, `IPRIO_OFF_FLAGS);
  wire wr_enable = wr_en && hit(paddr, `IPRIO_OFF_ENABLE);
  wire wr_prio = wr_en && hit(paddr, `IPRIO_OFF_PRIO);
  wire wr_srl = wr_en && hit(paddr, `IPRIO_OFF_SRL);
  wire wr_hold = wr_en && hit(paddr, `IPRIO_OFF_HOLD);
  wire wr_mask = wr_en && hit(paddr, `IPRIO_OFF_MASK);

  // Flag updates are cut back to the implemented bits on purpose.
  wire [31:0] trap_next = w1c_next({28'h0000000, trap_reg}, {28'h0000000, trap_event},
                                   pwdata, wr_ctrl1);
  wire [31:0] flag_next = w1c_next({24'h000000, flag_reg}, {24'h000000, src_event},
                                   pwdata, wr_flags);

  reg [3:0] best_lvl;
  reg [6:0] best_vec;
  reg [3:0] lvl;
  reg usr_ok;
  integer i;

  always @* begin
    best_lvl = `IPRIO_LVL_ZERO;
    best_vec = `IPRIO_VEC_ZERO;
    lvl = `IPRIO_LVL_ZERO;
    usr_ok = 1'b0;
    for (i = 0; i < `IPRIO_NTRAP; i = i + 1) begin
      lvl = `IPRIO_TRAP_LVL_BASE + i[3:0];
      // Trap flags are never gated by enables, level masks or hold-off. [RL7] [RL10]
      if (trap_reg[i] && lvl > best_lvl) begin
        best_lvl = lvl;
        best_vec = i[6:0];
      end
    end
    for (i = 0; i < `IPRIO_NSRC; i = i + 1) begin
      lvl = {1'b0, prio_of(prio_reg, i)};
      usr_ok = flag_reg[i] && en_reg[i]; // [RL4]
      if (lvl == `IPRIO_LVL_ZERO) begin
        usr_ok = 1'b0; // [RL13]
      end
      if (hold_active && lvl >= `IPRIO_HOLD_LO && lvl <= `IPRIO_HOLD_HI) begin
        usr_ok = 1'b0; // [RL11] [RL12]
      end
      if (nest_dis_reg && !stk_empty) begin
        usr_ok = 1'b0; // [RL1]
      end
      if (usr_ok && lvl > best_lvl) begin
        best_lvl = lvl;
        best_vec = `IPRIO_VEC_USR_BASE + i[6:0];
      end
    end
  end

  // A strict compare against the CPU level means level 7 in the status byte
  // blocks every user source but still lets traps through. [RL8] [RL10]
  wire accept = (best_lvl > cpu_lvl_reg) && !stk_full;

  iprio_stack u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .push(take),
    .push_data({cpu_lvl_reg, srl_lo_reg, core_pc}),
    .pop(core_return),
    .pop_data(stk_data),
    .pop_valid(stk_valid),
    .empty(stk_empty),
    .full(stk_full)
  );

  iprio_hold u_hold (
    .pclk(pclk),
    .presetn(presetn),
    .load(wr_hold),
    .count(pwdata[`IPRIO_HOLD_W-1:0]),
    .active(hold_active),
    .remaining(hold_left)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      if (setup) begin
        case (paddr)
          `IPRIO_OFF_CTRL1: begin
            prdata_reg[`IPRIO_NESTING_DISABLE_BIT] <= nest_dis_reg;
            prdata_reg[`IPRIO_NTRAP-1:0] <= trap_reg;
          end
          `IPRIO_OFF_FLAGS: prdata_reg[`IPRIO_NSRC-1:0] <= flag_reg;
          `IPRIO_OFF_ENABLE: prdata_reg[`IPRIO_NSRC-1:0] <= en_reg;
          `IPRIO_OFF_PRIO: prdata_reg[`IPRIO_PRIO_ALL_W-1:0] <= prio_reg;
          `IPRIO_OFF_SRL: prdata_reg[7:0] <= srl_view;
          `IPRIO_OFF_LVLVEC: begin
            prdata_reg[`IPRIO_LVL_MSB:`IPRIO_LVL_LSB] <= lvl_out_reg; // [RL14]
            prdata_reg[`IPRIO_VEC_MSB:0] <= vec_out_reg; // [RL15]
          end
          `IPRIO_OFF_HOLD: prdata_reg[`IPRIO_HOLD_W-1:0] <= hold_left;
          `IPRIO_OFF_MASK: prdata_reg[`IPRIO_NSRC-1:0] <= mask_reg;
          default: pslverr_reg <= 1'b1;
        endcase
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nest_dis_reg <= 1'b0;
    end else if (wr_ctrl1) begin
      nest_dis_reg <= pwdata[`IPRIO_NESTING_DISABLE_BIT]; // [RL1]
    end
  end

  // Trap and source flags stay set until software clears them. [RL5] [RL7]
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_reg <= {`IPRIO_NTRAP{1'b0}};
      flag_reg <= {`IPRIO_NSRC{1'b0}};
    end else begin
      trap_reg <= trap_next[`IPRIO_NTRAP-1:0];
      flag_reg <= flag_next[`IPRIO_NSRC-1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= {`IPRIO_NSRC{1'b0}};
    end else if (wr_enable) begin
      en_reg <= pwdata[`IPRIO_NSRC-1:0]; // [RL4]
    end
  end

  // The mask only gates the summary irq line; the core request ignores it.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= {`IPRIO_NSRC{1'b0}};
    end else if (wr_mask) begin
      mask_reg <= pwdata[`IPRIO_NSRC-1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_reg <= `IPRIO_PRIO_RST; // [RL16]
    end else if (wr_prio) begin
      prio_reg <= pwdata[`IPRIO_PRIO_ALL_W-1:0];
    end
  end

  // CPU level: taking an interrupt raises it, a return restores the saved one,
  // and a software write may only change it while no trap is being served.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_lvl_reg <= `IPRIO_LVL_ZERO;
      srl_lo_reg <= {`IPRIO_SRL_LO_W{1'b0}};
    end else if (take) begin
      cpu_lvl_reg <= best_lvl;
    end else if (stk_valid) begin
      cpu_lvl_reg <= stk_data[`IPRIO_STK_W-1:`IPRIO_STK_W-4]; // [RL6]
      srl_lo_reg <= stk_data[`IPRIO_STK_W-5:16]; // [RL6]
    end else if (wr_srl) begin
      srl_lo_reg <= pwdata[`IPRIO_SRL_LO_W-1:0];
      if (!cpu_lvl_reg[3]) begin
        cpu_lvl_reg <= {1'b0, pwdata[`IPRIO_SRL_IPL_MSB:`IPRIO_SRL_IPL_LSB]}; // [RL8]
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_out_reg <= `IPRIO_LVL_ZERO;
      vec_out_reg <= `IPRIO_VEC_ZERO;
      req_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      lvl_out_reg <= best_lvl; // [RL14]
      vec_out_reg <= best_vec; // [RL15]
      // The request is withdrawn for the take cycle's successor and for the
      // restore cycle, so a stale level is never offered twice.
      req_reg <= accept && !take && !stk_valid && !core_return; // [RL5]
      irq_reg <= |(flag_reg & mask_reg);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign core_irq_req = req_reg;
  assign core_irq_level = lvl_out_reg;
  assign core_irq_vector = vec_out_reg;
  assign ret_valid = stk_valid;
  assign ret_pc = stk_data[15:0]; // [RL6]
  assign irq = irq_reg;

endmodule
`default_nettype wire

// *** core/iprio_defs.vh ***
// Constants for the interrupt priority and status block.
// Assumes a 32-bit APB register bus and a single pclk domain.
`ifndef IPRIO_DEFS_VH
`define IPRIO_DEFS_VH

`define IPRIO_NSRC 8
`define IPRIO_NTRAP 4
`define IPRIO_PRIO_W 3
`define IPRIO_PRIO_ALL_W 24
`define IPRIO_PRIO_RST 24'h924924
`define IPRIO_LVL_ZERO 4'h0
`define IPRIO_USR_MAX_LVL 4'h7
`define IPRIO_TRAP_LVL_BASE 4'h8
`define IPRIO_HOLD_LO 4'h1
`define IPRIO_HOLD_HI 4'h6
`define IPRIO_VEC_USR_BASE 7'h04
`define IPRIO_VEC_ZERO 7'h00

`define IPRIO_OFF_CTRL1 8'h00
`define IPRIO_OFF_FLAGS 8'h04
`define IPRIO_OFF_ENABLE 8'h08
`define IPRIO_OFF_PRIO 8'h0c
`define IPRIO_OFF_SRL 8'h10
`define IPRIO_OFF_LVLVEC 8'h14
`define IPRIO_OFF_HOLD 8'h18
`define IPRIO_OFF_MASK 8'h1c

`define IPRIO_NESTING_DISABLE_BIT 15
`define IPRIO_SRL_IPL_MSB 7
`define IPRIO_SRL_IPL_LSB 5
`define IPRIO_SRL_LO_W 5
`define IPRIO_SRL_IPL7 3'h7
`define IPRIO_LVL_LSB 8
`define IPRIO_LVL_MSB 11
`define IPRIO_VEC_MSB 6

`define IPRIO_HOLD_W 14
`define IPRIO_STK_DEPTH 8
`define IPRIO_STK_AW 3
`define IPRIO_STK_W 25

`endif

// *** core/iprio_hold.v ***
// Timed hold-off counter started by a software write.
// Assumes load is a one-cycle pulse; a new load restarts the count.
`default_nettype none
`include "iprio_defs.vh"

module iprio_hold (
  input wire pclk,
  input wire presetn,
  input wire load,
  input wire [`IPRIO_HOLD_W-1:0] count,
  output wire active,
  output wire [`IPRIO_HOLD_W-1:0] remaining
);

  reg [`IPRIO_HOLD_W-1:0] cnt_reg;

  assign active = (cnt_reg != {`IPRIO_HOLD_W{1'b0}});
  assign remaining = cnt_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= {`IPRIO_HOLD_W{1'b0}};
    end else if (load) begin
      cnt_reg <= count;
    end else if (active) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

endmodule
`default_nettype wire

// *** core/iprio_stack.v ***
// Return stack holding the saved program counter, low status bits and CPU level.
// Assumes the caller never pushes when full nor pops when empty.
`default_nettype none
`include "iprio_defs.vh"

module iprio_stack (
  input wire pclk,
  input wire presetn,
  input wire push,
  input wire [`IPRIO_STK_W-1:0] push_data,
  input wire pop,
  output reg [`IPRIO_STK_W-1:0] pop_data,
  output reg pop_valid,
  output wire empty,
  output wire full
);

  reg [`IPRIO_STK_W-1:0] mem [0:`IPRIO_STK_DEPTH-1];
  reg [`IPRIO_STK_AW:0] sp_reg;

  assign empty = (sp_reg == {(`IPRIO_STK_AW+1){1'b0}});
  assign full = (sp_reg == `IPRIO_STK_DEPTH);

  // Storage has no reset; only the pointer and the pop outputs are reset.
  always @(posedge pclk) begin
    if (push && !full) begin
      mem[sp_reg[`IPRIO_STK_AW-1:0]] <= push_data;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_reg <= {(`IPRIO_STK_AW+1){1'b0}};
      pop_data <= {`IPRIO_STK_W{1'b0}};
      pop_valid <= 1'b0;
    end else begin
      pop_valid <= 1'b0;
      if (pop && !empty) begin
        pop_data <= mem[sp_reg[`IPRIO_STK_AW-1:0] - 1'b1];
        pop_valid <= 1'b1;
        sp_reg <= sp_reg - 1'b1;
      end else if (push && !full) begin
        sp_reg <= sp_reg + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// *** verification/iprio_core_model.sv ***
// Processor core model: takes an offered interrupt, serves it, returns.
// Assumes the block answers a take by dropping its request.
`default_nettype none
module iprio_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic core_irq_req,
  output logic core_take,
  output logic [15:0] core_pc,
  output logic core_return
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  // One routine at a time; the service time is fixed at six cycles.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_take <= 1'b0;
      core_return <= 1'b0;
      core_pc <= 16'h1000;
      cnt <= 4'h0;
    end else begin
      core_take <= 1'b0;
      core_return <= 1'b0;
      if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
        core_return <= (cnt == 4'h1);
      end else if (en && core_irq_req) begin
        core_take <= 1'b1;
        core_pc <= core_pc + 16'h0002;
        cnt <= 4'h6;
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/iprio_sva.sv ***
// Checker for the interrupt priority block; sees only the top ports.
// Assumes one pclk domain with presetn asynchronous and active low.
`default_nettype none
module iprio_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic core_take,
  input wire logic core_return,
  input wire logic core_irq_req,
  input wire logic [3:0] core_irq_level,
  input wire logic [6:0] core_irq_vector,
  input wire logic ret_valid
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (pready && paddr > 8'h1c |-> pslverr)
    else $error("unmapped access not refused");
  a_take_drops_req: assert property (core_take && core_irq_req |=> !core_irq_req)
    else $error("request stayed after take");
  a_req_level_set: assert property (core_irq_req |-> core_irq_level != 4'h0)
    else $error("request at level zero");
  a_trap_vector: assert property (core_irq_req && core_irq_level[3]
    |-> core_irq_vector == {4'h0, core_irq_level[2:0]}) else $error("bad trap vector");
  a_user_vector: assert property (core_irq_req && !core_irq_level[3]
    |-> core_irq_vector inside {[7'h04:7'h0b]}) else $error("bad user vector");
  a_ret_cause: assert property (ret_valid |-> $past(core_return))
    else $error("restore without return");
  a_ret_pulse: assert property (ret_valid |=> !ret_valid)
    else $error("restore pulse too long");
endmodule
bind iprio_ctrl iprio_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .core_take(core_take), .core_return(core_return), .core_irq_req(core_irq_req),
  .core_irq_level(core_irq_level), .core_irq_vector(core_irq_vector),
  .ret_valid(ret_valid));
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the interrupt priority block over APB.
// Assumes the core model file and the checker are compiled first.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, core_en, err;
  logic [7:0] paddr, src_event;
  logic [31:0] pwdata, rdata;
  logic [3:0] trap_event;
  logic [15:0] pc_seen;
  wire [31:0] prdata;
  wire pready, pslverr, core_take, core_return, core_irq_req, ret_valid, irq;
  wire [3:0] core_irq_level;
  wire [6:0] core_irq_vector;
  wire [15:0] core_pc, ret_pc;
  int n_fail, num_checks, takes;
  iprio_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_event(src_event), .trap_event(trap_event),
    .core_take(core_take), .core_pc(core_pc), .core_return(core_return),
    .core_irq_req(core_irq_req), .core_irq_level(core_irq_level),
    .core_irq_vector(core_irq_vector), .ret_valid(ret_valid), .ret_pc(ret_pc), .irq(irq));
  iprio_core_model u_core (.pclk(pclk), .presetn(presetn), .en(core_en),
    .core_irq_req(core_irq_req), .core_take(core_take), .core_pc(core_pc),
    .core_return(core_return));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: no pready", $time);
      final_report();
    end else begin
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wtake;
    int i;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (core_take !== 1'b1 && i < 20);
    if (core_take !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: no take", $time);
      final_report();
    end
  endtask
  task serve(input int n);
    repeat (n) begin
      @(posedge pclk);
      if (core_take === 1'b1) begin
        pc_seen = core_pc;
        takes++;
      end
      if (ret_valid === 1'b1) chk({16'h0, ret_pc}, {16'h0, pc_seen});
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask
  task ev(input logic [7:0] s, input logic [3:0] t);
    @(posedge pclk);
    src_event <= s;
    trap_event <= t;
    @(posedge pclk);
    src_event <= 8'h00;
    trap_event <= 4'h0;
  endtask
  // Request latency is one cycle, so four edges leave ample margin.
  task wreq(input logic v);
    repeat (4) @(posedge pclk);
    chk({31'h0, core_irq_req}, {31'h0, v});
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, src_event, trap_event} = '0;
    core_en = 1'b0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(8'h0c, 32'h00924924);
    rdc(8'h14, 32'h00000000);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    ev(8'h01, 4'h0);
    wreq(1'b0);
    rdc(8'h04, 32'h00000001);
    wr(8'h1c, 32'h00000001);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(8'h1c, 32'h00000000);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(8'h04, 32'h00000001);
    rdc(8'h04, 32'h00000000);
    wr(8'h0c, 32'h00924920);
    wr(8'h08, 32'h00000001);
    ev(8'h01, 4'h0);
    wreq(1'b0);
    wr(8'h0c, 32'h00924925);
    wreq(1'b1);
    rdc(8'h14, 32'h00000504);
    wr(8'h10, 32'h000000e0);
    wreq(1'b0);
    ev(8'h00, 4'h2);
    wreq(1'b1);
    chk({28'h0, core_irq_level}, 32'h9);
    wr(8'h00, 32'h00000002);
    wreq(1'b0);
    wr(8'h10, 32'h00000000);
    wreq(1'b1);
    wr(8'h18, 32'd60);
    wreq(1'b0);
    wr(8'h0c, 32'h0092493d);
    wr(8'h08, 32'h00000003);
    ev(8'h02, 4'h0);
    wreq(1'b1);
    chk({28'h0, core_irq_level}, 32'h7);
    wr(8'h04, 32'h00000002);
    repeat (60) @(posedge pclk);
    chk({28'h0, core_irq_level}, 32'h5);
    core_en <= 1'b1;
    serve(80);
    chk({31'h0, takes > 1}, 32'h1);
    core_en <= 1'b0;
    serve(15);
    wr(8'h04, 32'h00000001);
    takes = 0;
    repeat (2) @(posedge pclk);
    core_en <= 1'b1;
    serve(30);
    chk(takes, 32'd0);
    core_en <= 1'b0;
    wr(8'h00, 32'h00008000);
    wr(8'h0c, 32'h0092492b);
    ev(8'h01, 4'h0);
    core_en <= 1'b1;
    wtake();
    core_en <= 1'b0;
    ev(8'h02, 4'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, core_irq_req}, 32'h0);
    repeat (4) @(posedge pclk);
    wreq(1'b1);
    chk({28'h0, core_irq_level}, 32'h5);
    wr(8'h00, 32'h00000000);
    wr(8'h04, 32'h00000003);
    wr(8'h0c, 32'h006db6db);
    ev(8'h03, 4'h0);
    rdc(8'h14, 32'h00000304);
    final_report();
  end
endmodule
`default_nettype wire
